// [verilog/ebt_unit.sv]
// Break, trace, timer, sync and substitute program RAM logic of the emulation unit.
//
// Chosen here: the APB slave port and the placing of the registers.
`include "ebt_map.svh"
`default_nettype none
module ebt_unit
    import ebt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ebt_bond_t bond,
    output logic emu_run,
    output logic sub_sel,
    output logic [7:0] sub_data,
    input wire logic [1:0] sync_in,
    output logic [1:0] sync_out
);
    // Comparator words: index 0,1 break A/B, 2,3 qualifier A/B; cfg, value, data per comparator.
    logic [31:0] cmp_cfg [4];
    logic [31:0] cmp_val [4];
    logic [31:0] cmp_dat [4];
    logic [3:0] cmp_hit;
    ebt_state_t state;
    logic break_pend;
    logic [1:0] brk_flag;
    logic [31:0] timer;
    logic [4:0] presc;
    logic [1:0] tmode;
    logic trace_on;
    logic trig;
    logic wrapped;
    logic [9:0] wr_ptr;
    logic [9:0] t_count;
    logic [9:0] t_idx;
    ebt_frame_t trace_mem [1000];
    logic [7:0] sram [`EBT_SRAM_BYTES];
    logic [12:0] sram_ptr;
    logic [3:0] map_base [2];
    logic [1:0] map_en;
    logic [1:0] sync_ctl;
    logic [1:0] sync_cfg;
    logic [1:0] sync_s1;
    logic [1:0] sync_s2;
    logic [1:0] sync_d;
    logic [1:0] sync_lat;
    logic apb_wr;
    logic apb_rd;
    logic apb_setup;
    logic [31:0] next_rdata;
    logic mapped;
    logic store;
    logic qual;
    logic running;

    // One comparator test serves all four registers, so break and qualifier formats cannot drift apart.
    function automatic logic cmp_match(input logic [31:0] cfg, input logic [31:0] val,
                                       input logic [31:0] dat, input ebt_bond_t b);
        logic [7:0] mask;
        logic [7:0] port;
        logic hit;
        mask = dat[15:8];
        port = dat[16] ? b.port2 : b.port1;
        hit = 1'b0;
        case (cfg[2:0])
            EBT_K_EXACT: hit = b.op_fetch && (b.addr == val[15:0]); // RQ4
            EBT_K_RANGE: hit = b.op_fetch && (b.addr >= val[15:0]) && (b.addr <= val[31:16]); // RQ4
            EBT_K_OPCODE: hit = b.op_fetch && ((b.data & mask) == (dat[7:0] & mask)); // RQ5
            EBT_K_PORT: hit = (port & mask) == (dat[7:0] & mask); // RQ5
            EBT_K_OPND: hit = b.fetch && !b.op_fetch && ((b.data & mask) == (dat[7:0] & mask)); // RQ5
            EBT_K_OPND_ADDR: hit = b.fetch && !b.op_fetch && (b.addr == val[15:0]); // RQ5
            default: hit = 1'b0;
        endcase
        return hit && cfg[`EBT_CMP_EN];
    endfunction

    // All comparators look at the bond-out bus every cycle.
    for (genvar gi = 0; gi < 4; gi++) begin : g_cmp
        assign cmp_hit[gi] = cmp_match(cmp_cfg[gi], cmp_val[gi], cmp_dat[gi], bond); // RQ1 RQ2 RQ11
    end

    // APB phases; the slave always answers in the first access cycle.
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign pready = psel && penable;
    assign running = state != EBT_IDLE;
    assign emu_run = running; // RQ7
    assign qual = cmp_hit[2] || cmp_hit[3];

    // Comparator registers.
    for (genvar gc = 0; gc < 4; gc++) begin : g_cmp_reg
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                cmp_cfg[gc] <= `EBT_RST_WORD;
                cmp_val[gc] <= `EBT_RST_WORD;
                cmp_dat[gc] <= `EBT_RST_WORD;
            end else if (apb_wr && paddr[7:4] == (`EBT_CMP_BASE >> 4) + gc) begin
                if (paddr[3:2] == 2'h0) begin
                    cmp_cfg[gc] <= pwdata;
                end
                if (paddr[3:2] == 2'h1) begin
                    cmp_val[gc] <= pwdata;
                end
                if (paddr[3:2] == 2'h2) begin
                    cmp_dat[gc] <= pwdata;
                end
            end
        end
    end

    // Run control: a break is remembered until the current instruction completes, then the core idles.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= EBT_IDLE;
            break_pend <= 1'b0;
            brk_flag <= 2'b00;
        end else begin
            case (state)
                EBT_IDLE: begin
                    break_pend <= 1'b0;
                    if ((apb_wr && paddr == `EBT_CTRL && pwdata[`EBT_CTRL_GO]) ||
                        (sync_cfg[0] && sync_s2[0] && !sync_d[0])) begin // RQ13
                        state <= EBT_RUN; // RQ7
                        brk_flag <= 2'b00;
                    end else if (apb_wr && paddr == `EBT_CTRL && pwdata[`EBT_CTRL_STEP]) begin
                        state <= EBT_STEP; // RQ7
                        brk_flag <= 2'b00;
                    end
                end
                EBT_RUN: begin
                    brk_flag <= brk_flag | cmp_hit[1:0];
                    if (bond.insn_done && (break_pend || cmp_hit[0] || cmp_hit[1])) begin
                        state <= EBT_IDLE; // RQ3 RQ6 RQ18
                    end else if (cmp_hit[0] || cmp_hit[1] || (sync_cfg[1] && sync_s2[1]) ||
                                 (apb_wr && paddr == `EBT_CTRL && pwdata[`EBT_CTRL_HALT])) begin
                        break_pend <= 1'b1; // RQ2 RQ3 RQ18
                    end
                end
                EBT_STEP: begin
                    brk_flag <= brk_flag | cmp_hit[1:0];
                    if (bond.insn_done) begin
                        state <= EBT_IDLE; // RQ7
                    end
                end
                default: state <= EBT_IDLE;
            endcase
        end
    end

    // Microsecond timer; the prescaler only advances while emulating so idle time is excluded.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            presc <= 5'h00;
            timer <= `EBT_RST_WORD;
        end else if (apb_wr && paddr == `EBT_CTRL && pwdata[`EBT_CTRL_TCLR]) begin
            presc <= 5'h00;
            timer <= `EBT_RST_WORD;
        end else if (running) begin
            if (presc == `EBT_US_CYC - 5'h01) begin
                presc <= 5'h00;
                timer <= timer + 32'h1; // RQ17
            end else begin
                presc <= presc + 5'h01;
            end
        end
    end

    // Trace capture decision per mode; one frame per opcode fetch while the core runs or steps.
    always_comb begin
        store = 1'b0;
        if (trace_on && running && bond.op_fetch) begin // RQ8
            case (tmode)
                EBT_TM_FOREVER: store = 1'b1; // RQ12
                EBT_TM_QUAL: store = qual; // RQ12
                EBT_TM_PRE: store = !trig && !qual; // RQ12
                EBT_TM_POST: store = (trig || qual) && !wrapped; // RQ12
                default: store = 1'b0;
            endcase
        end
    end

    // Trace pointers; post-trigger mode stops at a full buffer, the others wrap and keep the newest.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tmode <= 2'b00;
            trace_on <= 1'b0;
            trig <= 1'b0;
            wrapped <= 1'b0;
            wr_ptr <= 10'h000;
            t_count <= 10'h000;
        end else if (apb_wr && paddr == `EBT_TRACE_CFG) begin
            tmode <= pwdata[1:0];
            trace_on <= pwdata[`EBT_TCFG_ON];
            if (pwdata[`EBT_TCFG_CLR]) begin
                trig <= trace_on && running && qual;
                wrapped <= 1'b0;
                wr_ptr <= 10'h000;
                t_count <= 10'h000;
            end
        end else begin
            if (trace_on && running && qual) begin
                trig <= 1'b1;
            end
            if (store) begin
                wr_ptr <= (wr_ptr == `EBT_TRACE_DEPTH - 10'd1) ? 10'h000 : wr_ptr + 10'h001; // RQ10
                if (t_count != `EBT_TRACE_DEPTH) begin
                    t_count <= t_count + 10'h001; // RQ10
                end
                if (wr_ptr == `EBT_TRACE_DEPTH - 10'd1) begin
                    wrapped <= 1'b1;
                end
            end
        end
    end

    // Trace memory write.
    always_ff @(posedge clk) begin
        if (store) begin
            trace_mem[wr_ptr] <= '{addr: bond.addr, opcode: bond.data, port1: bond.port1, port2: bond.port2}; // RQ9
        end
    end

    // Trace read index.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            t_idx <= 10'h000;
        end else if (apb_wr && paddr == `EBT_TRACE_IDX) begin
            t_idx <= (pwdata[9:0] < `EBT_TRACE_DEPTH) ? pwdata[9:0] : 10'h000;
        end
    end

    // Block map: two 4K windows of the 8K RAM, each placed on any 4K boundary.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            map_base[0] <= 4'h0;
            map_base[1] <= 4'h1;
            map_en <= 2'b00;
        end else if (apb_wr && paddr == `EBT_MAP) begin
            map_base[0] <= pwdata[3:0]; // RQ14
            map_en[0] <= pwdata[4];
            map_base[1] <= pwdata[11:8]; // RQ14
            map_en[1] <= pwdata[12];
        end
    end

    // Window 0 takes priority when both windows cover the same block.
    assign mapped = (map_en[0] && bond.addr[15:12] == map_base[0]) || (map_en[1] && bond.addr[15:12] == map_base[1]);

    // Substitute RAM answers a mapped fetch one cycle later; only the bond-out side is driven.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sub_sel <= 1'b0;
            sub_data <= 8'h00;
        end else begin
            sub_sel <= bond.fetch && mapped; // RQ15 RQ16
            if (map_en[0] && bond.addr[15:12] == map_base[0]) begin
                sub_data <= sram[{1'b0, bond.addr[11:0]}]; // RQ15
            end else begin
                sub_data <= sram[{1'b1, bond.addr[11:0]}]; // RQ15
            end
        end
    end

    // Host port into the RAM; the pointer steps after each data access.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sram_ptr <= 13'h0000;
        end else if (apb_wr && paddr == `EBT_SRAM_ADDR) begin
            sram_ptr <= pwdata[12:0];
        end else if (pready && paddr == `EBT_SRAM_DATA) begin
            sram_ptr <= sram_ptr + 13'h0001;
        end
    end

    // RAM host write.
    always_ff @(posedge clk) begin
        if (apb_wr && paddr == `EBT_SRAM_DATA) begin
            sram[sram_ptr] <= pwdata[7:0]; // RQ14
        end
    end

    // Sync pins pass two flops; a high level is latched until cleared, and a new level beats the clear.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_s1 <= 2'b00;
            sync_s2 <= 2'b00;
            sync_d <= 2'b00;
            sync_lat <= 2'b00;
        end else begin
            sync_s1 <= sync_in;
            sync_s2 <= sync_s1;
            sync_d <= sync_s2;
            if (apb_wr && paddr == `EBT_SYNC && pwdata[`EBT_SYNC_CLR]) begin
                sync_lat <= sync_s2; // RQ13
            end else begin
                sync_lat <= sync_lat | sync_s2; // RQ13
            end
        end
    end

    // Sync control and output lines.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_ctl <= 2'b00;
            sync_cfg <= 2'b00;
            sync_out <= 2'b00;
        end else begin
            if (apb_wr && paddr == `EBT_SYNC) begin
                sync_ctl <= pwdata[1:0];
                sync_cfg <= {pwdata[`EBT_SYNC_STOP], pwdata[`EBT_SYNC_GO]};
            end
            sync_out <= {sync_ctl[1], sync_ctl[0] | running}; // RQ13
        end
    end

    // Read multiplexer; the word is captured in the setup cycle so prdata comes from a flop.
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            `EBT_STATUS: next_rdata = {24'h0, 2'b00, wrapped, trig, brk_flag, state};
            `EBT_TRACE_CFG: next_rdata = {28'h0, 1'b0, trace_on, tmode};
            `EBT_TRACE_CNT: next_rdata = {6'h0, wr_ptr, 6'h0, t_count};
            `EBT_TRACE_IDX: next_rdata = {22'h0, t_idx};
            `EBT_TRACE_DAT0: next_rdata = {8'h0, trace_mem[t_idx].opcode, trace_mem[t_idx].addr};
            `EBT_TRACE_DAT1: next_rdata = {16'h0, trace_mem[t_idx].port2, trace_mem[t_idx].port1};
            `EBT_TIMER: next_rdata = timer;
            `EBT_MAP: next_rdata = {19'h0, map_en[1], map_base[1], 3'h0, map_en[0], map_base[0]};
            `EBT_SYNC: next_rdata = {22'h0, sync_lat, 4'h0, sync_cfg, sync_ctl};
            `EBT_SRAM_ADDR: next_rdata = {19'h0, sram_ptr};
            `EBT_SRAM_DATA: next_rdata = {24'h0, sram[sram_ptr]};
            default: begin
                if (paddr[7:6] == 2'b01 && paddr[3:2] != 2'h3) begin
                    next_rdata = (paddr[3:2] == 2'h0) ? cmp_cfg[paddr[5:4]] :
                                 (paddr[3:2] == 2'h1) ? cmp_val[paddr[5:4]] : cmp_dat[paddr[5:4]];
                end
            end
        endcase
    end

    // Read data and error flop; unmapped offsets answer with pslverr and zero.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= paddr[1:0] != 2'b00 || paddr > 8'h7b || (paddr > `EBT_SRAM_DATA && paddr < `EBT_CMP_BASE) ||
                       (paddr[7:6] == 2'b01 && paddr[3:2] == 2'h3);
        end
    end

    sequence s_apb_setup;
        psel && !penable;
    endsequence
    sequence s_apb_access;
        psel && penable;
    endsequence

    AST_APB_READY: assert property (@(posedge clk) disable iff (sys_rst) // RQ6
        s_apb_setup ##1 s_apb_access |-> pready) else $error("APB access not answered at once.");
    AST_BREAK_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
        state == EBT_RUN && cmp_hit[0] && !bond.insn_done |=> state == EBT_RUN) else $error("Stopped mid-instruction.");
    AST_BREAK_STOP: assert property (@(posedge clk) disable iff (sys_rst) // RQ18
        state == EBT_RUN && (cmp_hit[0] || cmp_hit[1]) && bond.insn_done |=> !emu_run) else $error("Break ignored.");
    AST_STEP_ONE: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
        state == EBT_STEP && bond.insn_done |=> state == EBT_IDLE ##1 !emu_run) else $error("Step ran on.");
    AST_TIMER_TICK: assert property (@(posedge clk) disable iff (sys_rst) // RQ17
        running && presc == `EBT_US_CYC - 5'h01 && !apb_wr |=> timer == $past(timer) + 32'h1) else $error("Timer stuck.");
    AST_TRACE_CNT: assert property (@(posedge clk) disable iff (sys_rst) // RQ10
        store && t_count < `EBT_TRACE_DEPTH && !apb_wr |=> t_count == $past(t_count) + 10'h001) else $error("Count lost.");
    AST_TRACE_POST: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
        tmode == EBT_TM_POST && !trig && !qual |-> !store) else $error("Post trace before trigger.");
    AST_TRACE_PRE: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
        tmode == EBT_TM_PRE && trig |-> !store) else $error("Pre trace after trigger.");
    AST_SRAM_HIT: assert property (@(posedge clk) disable iff (sys_rst) // RQ15
        bond.fetch && mapped |=> sub_sel) else $error("Mapped fetch not served.");
    AST_SRAM_MISS: assert property (@(posedge clk) disable iff (sys_rst) // RQ14
        !(bond.fetch && mapped) |=> !sub_sel) else $error("Unmapped fetch served.");
    AST_SYNC_LATCH: assert property (@(posedge clk) disable iff (sys_rst) // RQ13
        sync_s2[0] |=> sync_lat[0]) else $error("Sync input not latched.");
    AST_SYNC_OUT: assert property (@(posedge clk) disable iff (sys_rst) // RQ13
        running |=> sync_out[0]) else $error("Sync output low while running.");
endmodule
`default_nettype wire

// [verilog/ebt_map.svh]
// Register offsets, field positions, reset values and timing counts of the break and trace unit.
//Contract
//RQ1: Two independent breakpoint comparator registers.
//RQ2: Compare every cycle; halt when satisfied.
//RQ3: Breaking instruction completes before processor stops.
//RQ4: Match exact execution address or range.
//RQ5: Match opcode, port level, operand, operand address.
//RQ6: After break, idle in interrogation for host.
//RQ7: Real-time run and single-instruction stepping.
//RQ8: Trace during run and during stepping.
//RQ9: Frame holds opcode, port values, address.
//RQ10: Trace buffer holds 1000 frames.
//RQ11: Two qualifier registers, same match format.
//RQ12: Modes: forever, qualified, pre-trigger, post-trigger.
//RQ13: Drive sync outputs, latch sync inputs.
//RQ14: 8K substitute RAM mapped in 4K blocks.
//RQ15: Mapped RAM answers program fetches instead.
//RQ16: Observe bond-out only; never drive user pins.
//RQ17: Emulation timer counts microseconds, host readable.
//RQ18: Either breakpoint alone halts emulation.
`ifndef EBT_MAP_SVH
`define EBT_MAP_SVH
`define EBT_CTRL 8'h00
`define EBT_STATUS 8'h04
`define EBT_TRACE_CFG 8'h08
`define EBT_TRACE_CNT 8'h0c
`define EBT_TRACE_IDX 8'h10
`define EBT_TRACE_DAT0 8'h14
`define EBT_TRACE_DAT1 8'h18
`define EBT_TIMER 8'h1c
`define EBT_MAP 8'h20
`define EBT_SYNC 8'h24
`define EBT_SRAM_ADDR 8'h28
`define EBT_SRAM_DATA 8'h2c
`define EBT_CMP_BASE 8'h40
`define EBT_CTRL_GO 0
`define EBT_CTRL_STEP 1
`define EBT_CTRL_HALT 2
`define EBT_CTRL_TCLR 3
`define EBT_TCFG_ON 2
`define EBT_TCFG_CLR 3
`define EBT_CMP_EN 8
`define EBT_SYNC_GO 2
`define EBT_SYNC_STOP 3
`define EBT_SYNC_CLR 16
`define EBT_RST_WORD 32'h0000_0000
`define EBT_TRACE_DEPTH 10'd1000
`define EBT_SRAM_BYTES 8192
`define EBT_US_NS 1000
`define EBT_CLK_NS 50
`define EBT_US_CYC 5'((`EBT_US_NS + `EBT_CLK_NS - 1) / `EBT_CLK_NS)
`endif

// [verilog/ebt_pkg.sv]
// Types shared by the break and trace unit.
`default_nettype none
package ebt_pkg;
    typedef enum logic [1:0] {
        EBT_IDLE = 2'b00,
        EBT_RUN = 2'b01,
        EBT_STEP = 2'b10
    } ebt_state_t;
    typedef enum logic [2:0] {
        EBT_K_EXACT = 3'b000,
        EBT_K_RANGE = 3'b001,
        EBT_K_OPCODE = 3'b010,
        EBT_K_PORT = 3'b011,
        EBT_K_OPND = 3'b100,
        EBT_K_OPND_ADDR = 3'b101
    } ebt_kind_t;
    typedef enum logic [1:0] {
        EBT_TM_FOREVER = 2'b00,
        EBT_TM_QUAL = 2'b01,
        EBT_TM_PRE = 2'b10,
        EBT_TM_POST = 2'b11
    } ebt_tmode_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic [7:0] port1;
        logic [7:0] port2;
        logic fetch;
        logic op_fetch;
        logic insn_done;
    } ebt_bond_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] opcode;
        logic [7:0] port1;
        logic [7:0] port2;
    } ebt_frame_t;
endpackage
`default_nettype wire

// [verification/ebt_cpu_model.sv]
// Behavioural bond-out processor model that runs two-byte instructions while allowed to.
`default_nettype none
module ebt_cpu_model
    import ebt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic emu_run,
    input wire logic load,
    input wire logic [15:0] new_pc,
    input wire logic [7:0] p1,
    input wire logic [7:0] p2,
    output ebt_bond_t bond
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] pc;
    logic ph;
    // Advance only while allowed, so a stop always lands on an instruction boundary.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc <= 16'h0000;
            ph <= 1'b0;
        end else if (load) begin
            pc <= new_pc;
            ph <= 1'b0;
        end else if (emu_run) begin
            ph <= ~ph;
            if (ph) begin
                pc <= pc + 16'h0002;
            end
        end
    end
    // Opcode byte then operand byte; idle cycles show inverted data so stale values never match.
    always_comb begin
        bond.addr = ph ? {pc[15:1], 1'b1} : pc;
        bond.data = ph ? ~{pc[7:1], 1'b1} : (pc[7:0] ^ 8'h5a);
        if (!emu_run) begin
            bond.data = ~bond.data;
        end
        bond.port1 = p1;
        bond.port2 = p2;
        bond.fetch = emu_run;
        bond.op_fetch = emu_run & ~ph;
        bond.insn_done = emu_run & ph;
    end
endmodule
`default_nettype wire

// [verification/emulation_break_trace_unit_tb_top.sv]
// Self-checking bench for the break, trace, timer, sync and substitute RAM unit.
`default_nettype none
module emulation_break_trace_unit_tb_top
    import ebt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, emu_run, sub_sel, load, rerr, pf, sub_ok;
    logic [7:0] paddr, sub_data, p1, p2, sub_b, b;
    logic [31:0] pwdata, prdata, rdat, pp;
    logic [1:0] sync_in, sync_out;
    logic [15:0] new_pc, last_done, pa, t, t0;
    ebt_bond_t bond;
    int seed = 53593;
    int bad_count = 0;
    int n_tests = 0;
    int ndone = 0;
    int run_cyc = 0;
    int nsub = 0;
    int n, d0, r0, e;
    ebt_unit i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bond(bond),
        .emu_run(emu_run), .sub_sel(sub_sel), .sub_data(sub_data), .sync_in(sync_in), .sync_out(sync_out));
    ebt_cpu_model i_cpu (.clk(clk), .sys_rst(sys_rst), .emu_run(emu_run), .load(load), .new_pc(new_pc),
        .p1(p1), .p2(p2), .bond(bond));
    // A 50 ns clock.
    always #25 clk = ~clk;
    // Watch completions, run time and the byte after a fetch.
    always @(posedge clk) begin
        if (bond.insn_done) begin
            last_done <= bond.addr;
            ndone <= ndone + 1;
        end
        if (emu_run) run_cyc <= run_cyc + 1;
        if (sub_sel) nsub <= nsub + 1;
        if (pf && pa == 16'h4010) begin
            sub_ok <= sub_sel;
            sub_b <= sub_data;
        end
        pf <= bond.op_fetch;
        pa <= bond.addr;
    end
    task automatic give_verdict();
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic stall();
        bad_count++;
        $display("mismatch wait expected done seen timeout");
        give_verdict();
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        n_tests++;
        if (g !== ex) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, ex, g);
        end
    endtask
    // One APB transfer; the request is held until pready is seen at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) stall();
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_run(input logic v, input int lim);
        int k;
        k = 0;
        while (emu_run !== v && k < lim) begin
            @(posedge clk);
            k++;
        end
        if (emu_run !== v) stall();
    endtask
    task automatic run_cmd(input logic [31:0] d, input int lim);
        wr(8'h00, d);
        wait_run(1'b1, 4);
        wait_run(1'b0, lim);
    endtask
    // Value and data words first, enable last, so a half-written comparator never arms.
    task automatic cmp(input logic [7:0] a, input logic [2:0] k, input logic [31:0] v, input logic [31:0] dt);
        wr(a + 8'h04, v);
        wr(a + 8'h08, dt);
        wr(a, {23'h0, 1'b1, 5'h0, k});
    endtask
    task automatic clear();
        for (int i = 4; i < 8; i++) wr(8'(i * 16), 32'h0);
    endtask
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, load, paddr, pwdata, sync_in, new_pc, p1, p2} = '0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h04);
        chk("status_reset", 32'h0, rdat);
        rd(8'h20);
        chk("map_reset", 32'h100, rdat);
        rd(8'h30);
        chk("unmapped_err", 32'h1, {31'h0, rerr});
        rd(8'h02);
        chk("misaligned_err", 32'h1, {31'h0, rerr});
        // Every match kind, alternating between the two break registers.
        for (int k = 0; k < 6; k++) begin
            b = k[0] ? 8'h50 : 8'h40;
            clear();
            p2 <= (k == 3) ? 8'hc3 : 8'h00;
            n = 2 + ($unsigned($random(seed)) % 8);
            t = (k == 3) ? i_cpu.pc : i_cpu.pc + 16'(2 * n);
            case (k)
                0: cmp(b, EBT_K_EXACT, {16'h0, t}, 32'h0);
                1: cmp(b, EBT_K_RANGE, {t + 16'h4, t}, 32'h0);
                2: cmp(b, EBT_K_OPCODE, 32'h0, {16'h00ff, t[7:0] ^ 8'h5a});
                3: cmp(b, EBT_K_PORT, 32'h0, 32'h1ffc3);
                4: cmp(b, EBT_K_OPND, 32'h0, {16'h00ff, ~(t[7:0] | 8'h01)});
                default: cmp(b, EBT_K_OPND_ADDR, {16'h0, t + 16'h1}, 32'h0);
            endcase
            run_cmd(32'h1, 400);
            chk("break_done_addr", {16'h0, t + 16'h1}, {16'h0, last_done});
            rd(8'h04);
            chk("break_flags", k[0] ? 32'h8 : 32'h4, rdat & 32'h0f);
        end
        d0 = ndone;
        run_cmd(32'h2, 40);
        chk("step_count", 32'h1, 32'(ndone - d0));
        // Unconditional capture overruns the buffer; the timer runs.
        clear();
        pp = $random(seed);
        p1 <= pp[7:0];
        p2 <= pp[15:8];
        wr(8'h08, 32'h0c);
        wr(8'h00, 32'h8);
        t0 = i_cpu.pc;
        cmp(8'h40, EBT_K_EXACT, {16'h0, t0 + 16'd2200}, 32'h0);
        r0 = run_cyc;
        run_cmd(32'h1, 3000);
        rd(8'h0c);
        chk("trace_count", 32'd1000, rdat & 32'h3ff);
        chk("trace_wptr", 32'd101, {22'h0, rdat[25:16]});
        wr(8'h10, 32'h0);
        rd(8'h14);
        t = t0 + 16'd2000;
        chk("frame_op_addr", {8'h0, t[7:0] ^ 8'h5a, t}, rdat);
        rd(8'h18);
        chk("frame_ports", {16'h0, pp[15:0]}, rdat);
        rd(8'h1c);
        e = (run_cyc - r0) / 20;
        chk("timer_us", 32'h1, {31'h0, rdat + 1 >= e && rdat <= e + 1});
        // Qualified capture, then pre-trigger capture.
        clear();
        t0 = i_cpu.pc;
        wr(8'h08, 32'h0d);
        cmp(8'h60, EBT_K_EXACT, {16'h0, t0 + 16'h6}, 32'h0);
        cmp(8'h40, EBT_K_EXACT, {16'h0, t0 + 16'hc}, 32'h0);
        run_cmd(32'h1, 200);
        rd(8'h0c);
        chk("qual_count", 32'h1, rdat & 32'h3ff);
        wr(8'h08, 32'h0e);
        wr(8'h64, {16'h0, t0 + 16'h14});
        wr(8'h44, {16'h0, t0 + 16'h1a});
        run_cmd(32'h1, 200);
        rd(8'h0c);
        chk("pre_count", 32'h3, rdat & 32'h3ff);
        // Sync outputs, latched inputs and a start on an external edge.
        clear();
        wr(8'h24, 32'h2);
        repeat (2) @(posedge clk);
        chk("sync_out_idle", 32'h2, {30'h0, sync_out});
        sync_in <= 2'b10;
        repeat (4) @(posedge clk);
        sync_in <= 2'b00;
        rd(8'h24);
        chk("sync_latch", 32'h200, rdat & 32'h300);
        wr(8'h24, 32'h10004);
        rd(8'h24);
        chk("sync_clear", 32'h0, rdat & 32'h300);
        sync_in <= 2'b01;
        wait_run(1'b1, 10);
        repeat (2) @(posedge clk);
        chk("sync_out_run", 32'h1, {30'h0, sync_out});
        sync_in <= 2'b00;
        wr(8'h00, 32'h4);
        wait_run(1'b0, 20);
        chk("sub_unmapped", 32'h0, nsub);
        // Substitute RAM mapped at the fifth 4K block answers a fetch there.
        @(posedge clk);
        load <= 1'b1;
        new_pc <= 16'h4000;
        @(posedge clk);
        load <= 1'b0;
        wr(8'h20, 32'h14);
        wr(8'h28, 32'h10);
        wr(8'h2c, 32'h77);
        cmp(8'h40, EBT_K_EXACT, 32'h4012, 32'h0);
        run_cmd(32'h1, 100);
        chk("sub_sel", 32'h1, {31'h0, sub_ok});
        chk("sub_data", 32'h77, {24'h0, sub_b});
        give_verdict();
    end
endmodule
`default_nettype wire
